// file: src/mps_sequencer.sv
// multiphase pwm sequencer: strap detect, interleave, balance, vid mode
//
// What this block does
// - straps select one to four core channels
// - four channels fire 1-2-3-4, quarter spaced
// - three channels fire 1-2-3, third spaced
// - two channels: second fires half cycle later
// - cycle length equals programmed switching period
// - alignment trigger turns on only armed active phases (own slot start seen, not yet risen)
// - channel currents sampled continuously each cycle
// - average equals active sum over count
// - width corrected by average minus sample
// - enable low: regulators off, select sampled
// - enable rise latches select: high parallel
// - each active phase rises at most once per interval
// - parallel mode keeps northbridge regulator off
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "mps_regs.svh"
module mps_sequencer #(
	parameter int CW = 8,
	parameter int PW = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// board pins
	input wire logic core_enable,
	input wire logic vid_mode_select,
	input wire logic chan2_sense_strap,
	input wire logic chan3_sense_strap,
	input wire logic chan4_sense_strap,
	input wire logic phase_align_trigger,
	// sensed channel currents, same clock
	input wire logic [3:0][CW-1:0] chan_current,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// gate driver pulses
	output logic phase_pulse_1,
	output logic phase_pulse_2,
	output logic phase_pulse_3,
	output logic phase_pulse_4,
	// regulator and mode status
	output logic core_reg_en,
	output logic nb_reg_en,
	output logic parallel_vid_mode,
	output logic serial_vid_mode,
	output logic [2:0] active_chan_count,
	output logic [CW-1:0] cycle_avg_current
);

	// reset release through two flops
	logic [1:0] rst_q;
	logic rst_core_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_core_n = rst_q[1];

	// pin synchroniser: a change counts once stages two and three agree
	mps_pkg::mps_pins_t pin_raw;
	mps_pkg::mps_pins_t pin_s1;
	mps_pkg::mps_pins_t pin_s2;
	mps_pkg::mps_pins_t pin_s3;
	mps_pkg::mps_pins_t pin;
	mps_pkg::mps_pins_t next_pin;

	always_comb begin
		pin_raw.align = phase_align_trigger;
		pin_raw.strap4 = chan4_sense_strap;
		pin_raw.strap3 = chan3_sense_strap;
		pin_raw.strap2 = chan2_sense_strap;
		pin_raw.sel = vid_mode_select;
		pin_raw.en = core_enable;
		// stage one is only read by stage two
		next_pin = (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin & (pin_s2 ^ pin_s3));
	end

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin <= next_pin;
		end
	end

	// apb registers
	logic ctrl_run;
	logic [PW-1:0] period;
	logic [PW-1:0] duty;
	logic next_ctrl_run;
	logic [PW-1:0] next_period;
	logic [PW-1:0] next_duty;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// run state and latched mode
	mps_pkg::mps_state_t state;
	mps_pkg::mps_state_t next_state;
	logic en_prev;
	logic next_core_reg_en;
	logic next_nb_reg_en;
	logic next_parallel;
	logic [2:0] next_count;

	// cycle timing and balance
	logic [PW-1:0] cyc_cnt;
	logic [PW-1:0] next_cyc_cnt;
	logic [3:0][CW-1:0] sample;
	logic [3:0][PW-1:0] chan_width;
	logic [3:0][PW-1:0] next_chan_width;
	logic [CW-1:0] next_avg;
	logic [3:0] slot_start;
	logic [3:0] chan_active;
	logic running;
	logic force_all;

	// bus: one wait state, then the answer with pready
	always_comb begin
		logic setup_wait;
		logic done;
		logic mapped;
		setup_wait = psel & penable & ~pready;
		done = psel & penable & pready;
		mapped = 1'b0;
		next_ctrl_run = ctrl_run;
		next_period = period;
		next_duty = duty;
		next_prdata = 32'h00000000;
		next_pready = setup_wait;
		mapped = (paddr == `MPS_ADDR_CTRL) || (paddr == `MPS_ADDR_PERIOD) ||
			(paddr == `MPS_ADDR_DUTY) || (paddr == `MPS_ADDR_STATUS) ||
			(paddr == `MPS_ADDR_AVG);
		next_pslverr = setup_wait & ~mapped;
		if (setup_wait && !pwrite) begin
			case (paddr)
				`MPS_ADDR_CTRL: next_prdata[`MPS_CTRL_RUN] = ctrl_run;
				`MPS_ADDR_PERIOD: next_prdata[PW-1:0] = period;
				`MPS_ADDR_DUTY: next_prdata[PW-1:0] = duty;
				`MPS_ADDR_STATUS: begin
					next_prdata[`MPS_STAT_CNT_MSB:`MPS_STAT_CNT_LSB] =
						active_chan_count;
					next_prdata[`MPS_STAT_PARALLEL] = parallel_vid_mode;
					next_prdata[`MPS_STAT_ENABLED] = core_reg_en;
					next_prdata[`MPS_STAT_ALIGN] = force_all;
				end
				`MPS_ADDR_AVG: next_prdata[CW-1:0] = cycle_avg_current;
				default: next_prdata = 32'h00000000;
			endcase
		end
		if (done && pwrite) begin
			case (paddr)
				`MPS_ADDR_CTRL: next_ctrl_run = pwdata[`MPS_CTRL_RUN];
				// a period below the minimum would collapse the slots
				`MPS_ADDR_PERIOD: next_period = (pwdata[PW-1:0] <
					`MPS_PERIOD_MIN) ? `MPS_PERIOD_MIN : pwdata[PW-1:0];
				`MPS_ADDR_DUTY: next_duty = pwdata[PW-1:0];
				default: next_duty = duty;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			ctrl_run <= `MPS_CTRL_RST;
			period <= `MPS_PERIOD_RST;
			duty <= `MPS_DUTY_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl_run <= next_ctrl_run;
			period <= next_period;
			duty <= next_duty;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// enable, mode latch and channel detection
	always_comb begin
		logic [2:0] strap_count;
		strap_count = 3'h4;
		// straps tie sense-minus pins to supply to drop channels
		if (pin.strap4 && pin.strap3 && pin.strap2) begin
			strap_count = 3'h1;
		end else if (pin.strap4 && pin.strap3) begin
			strap_count = 3'h2;
		end else if (pin.strap4) begin
			strap_count = 3'h3;
		end else begin
			strap_count = 3'h4;
		end
		next_state = state;
		next_parallel = parallel_vid_mode;
		next_count = active_chan_count;
		case (state)
			mps_pkg::MPS_OFF: begin
				// select and straps tracked while disabled
				next_parallel = pin.sel;
				next_count = strap_count;
				if (pin.en && !en_prev) begin
					// value seen at the rising edge is held; the
					// board keeps select settled well ahead of it
					next_state = mps_pkg::MPS_RUN;
				end
			end
			mps_pkg::MPS_RUN: begin
				if (!pin.en) begin
					next_state = mps_pkg::MPS_OFF;
				end
			end
			default: next_state = mps_pkg::MPS_OFF;
		endcase
		next_core_reg_en = (next_state == mps_pkg::MPS_RUN);
		// northbridge only runs in serial mode
		next_nb_reg_en = next_core_reg_en & ~next_parallel;
	end

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state <= mps_pkg::MPS_OFF;
			en_prev <= 1'b0;
			core_reg_en <= 1'b0;
			nb_reg_en <= 1'b0;
			parallel_vid_mode <= 1'b0;
			serial_vid_mode <= 1'b1;
			active_chan_count <= 3'h4;
		end else begin
			state <= next_state;
			en_prev <= pin.en;
			core_reg_en <= next_core_reg_en;
			nb_reg_en <= next_nb_reg_en;
			parallel_vid_mode <= next_parallel;
			serial_vid_mode <= ~next_parallel;
			active_chan_count <= next_count;
		end
	end

	assign running = core_reg_en & ctrl_run;
	assign force_all = running & pin.align;

	// interval counter and slot positions
	always_comb begin
		logic [PW-1:0] slot;
		logic [PW+1:0] offs;
		slot = '0;
		offs = '0;
		next_cyc_cnt = '0;
		if (running && cyc_cnt < period - PW'(1)) begin
			next_cyc_cnt = cyc_cnt + PW'(1);
		end
		case (active_chan_count)
			3'h4: slot = period >> 2;
			3'h3: slot = period / PW'(3);
			3'h2: slot = period >> 1;
			default: slot = period;
		endcase
		for (int k = 0; k < 4; k++) begin
			offs = (PW+2)'(slot) * (PW+2)'(k);
			chan_active[k] = running && (3'(k) < active_chan_count);
			slot_start[k] = chan_active[k] && (cyc_cnt == offs[PW-1:0]);
		end
	end

	// current balance: average at interval end, correct each width
	always_comb begin
		logic [CW+1:0] sum;
		logic [CW+1:0] avg;
		logic signed [PW+1:0] err;
		logic signed [PW+1:0] w;
		avg = '0;
		err = '0;
		w = '0;
		sum = '0;
		for (int k = 0; k < 4; k++) begin
			if (3'(k) < active_chan_count) begin
				sum = sum + (CW+2)'(sample[k]);
			end
		end
		case (active_chan_count)
			3'h4: avg = sum >> 2;
			3'h3: avg = sum / (CW+2)'(3);
			3'h2: avg = sum >> 1;
			default: avg = sum;
		endcase
		next_avg = cycle_avg_current;
		next_chan_width = chan_width;
		if (cyc_cnt == period - PW'(1) || !running) begin
			next_avg = avg[CW-1:0];
			for (int k = 0; k < 4; k++) begin
				err = $signed((PW+2)'(avg)) - $signed((PW+2)'(sample[k]));
				w = $signed((PW+2)'(duty)) + (err >>> `MPS_BAL_SHIFT);
				if (w < 0) begin
					next_chan_width[k] = '0;
				end else if (w >= $signed((PW+2)'(period))) begin
					next_chan_width[k] = period - PW'(1);
				end else begin
					next_chan_width[k] = w[PW-1:0];
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			cyc_cnt <= '0;
			sample <= '0;
			chan_width <= '0;
			cycle_avg_current <= '0;
		end else begin
			cyc_cnt <= next_cyc_cnt;
			sample <= chan_current;
			chan_width <= next_chan_width;
			cycle_avg_current <= next_avg;
		end
	end

	// four phase channels
	logic [3:0] pulse;

	for (genvar g = 0; g < 4; g++) begin : g_chan
		mps_phase_chan #(
			.W(PW)
		) u_chan (
			.core_clk(core_clk),
			.rst_n(rst_core_n),
			.active(chan_active[g]),
			.start(slot_start[g]),
			.force_on(force_all),
			.width(chan_width[g]),
			.pulse(pulse[g])
		);
	end

	assign phase_pulse_1 = pulse[0];
	assign phase_pulse_2 = pulse[1];
	assign phase_pulse_3 = pulse[2];
	assign phase_pulse_4 = pulse[3];

endmodule

// file: src/mps_regs.svh
// register map, field positions, reset values and timing counts
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH

// byte addresses of the apb registers
`define MPS_ADDR_CTRL 8'h00
`define MPS_ADDR_PERIOD 8'h04
`define MPS_ADDR_DUTY 8'h08
`define MPS_ADDR_STATUS 8'h0C
`define MPS_ADDR_AVG 8'h10

// field positions
`define MPS_CTRL_RUN 0
`define MPS_STAT_CNT_LSB 0
`define MPS_STAT_CNT_MSB 2
`define MPS_STAT_PARALLEL 4
`define MPS_STAT_ENABLED 5
`define MPS_STAT_ALIGN 6

// reset values and minimum period
`define MPS_CTRL_RST 1'h1
`define MPS_PERIOD_RST 16'h0064
`define MPS_DUTY_RST 16'h0014
`define MPS_PERIOD_MIN 16'h0004

// balance loop gain as a right shift of the error
`define MPS_BAL_SHIFT 2

// timing: clock period and mode-select setup before enable rises
`define MPS_CLK_NS 100
`define MPS_SEL_SETUP_NS 1000
`define MPS_SEL_SETUP_CYC ((`MPS_SEL_SETUP_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)

`endif

// file: src/mps_pkg.sv
// types shared by the phase sequencer files
package mps_pkg;

	// synchronised pin group
	typedef struct packed {
		logic align;
		logic strap4;
		logic strap3;
		logic strap2;
		logic sel;
		logic en;
	} mps_pins_t;

	// regulator run state
	typedef enum logic {
		MPS_OFF,
		MPS_RUN
	} mps_state_t;

endpackage

// file: src/mps_phase_chan.sv
// one phase output: slot start, width count, forced turn-on
`timescale 1ns/1ps
module mps_phase_chan #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic active,
	input wire logic start,
	input wire logic force_on,
	input wire logic [W-1:0] width,
	// gate driver pulse
	output logic pulse
);

	logic armed;
	logic [W-1:0] cnt;
	logic next_pulse;
	logic next_armed;
	logic [W-1:0] next_cnt;

	// arm at own slot, rise at most once per interval
	always_comb begin
		logic arm_now;
		logic rise;
		arm_now = armed | start;
		rise = active & arm_now & ((start & (width != '0)) | force_on);
		next_pulse = pulse;
		next_armed = arm_now;
		next_cnt = cnt;
		if (!active) begin
			next_pulse = 1'b0;
			next_armed = 1'b0;
			next_cnt = '0;
		end else if (rise && !pulse) begin
			next_pulse = 1'b1;
			next_armed = 1'b0;
			next_cnt = (width == '0) ? W'(1) : width;
		end else if (pulse) begin
			// termination after the commanded width
			if (cnt <= W'(1)) begin
				next_pulse = 1'b0;
				next_cnt = '0;
			end else begin
				next_cnt = cnt - W'(1);
			end
		end
	end

	// register the channel state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse <= 1'b0;
			armed <= 1'b0;
			cnt <= '0;
		end else begin
			pulse <= next_pulse;
			armed <= next_armed;
			cnt <= next_cnt;
		end
	end

endmodule

// file: verification/mps_seq_sva.sv
// assertions on the phase sequencer ports
`timescale 1ns/1ps
module mps_seq_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// apb handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// pulses and mode
	input wire logic phase_pulse_1,
	input wire logic phase_pulse_4,
	input wire logic core_reg_en,
	input wire logic nb_reg_en,
	input wire logic parallel_vid_mode,
	input wire logic serial_vid_mode,
	input wire logic [2:0] active_chan_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// apb answer comes after exactly one wait state and stands one cycle
	a_ready_one_wait: assert property (psel && penable && !pready
		&& $past(psel && !penable) |=> pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_in_access: assert property (pslverr |-> pready && penable)
		else $error("pslverr outside access");
	// mode and regulator enables
	a_mode_pair: assert property (parallel_vid_mode != serial_vid_mode)
		else $error("mode outputs agree");
	a_nb_parallel_off: assert property (parallel_vid_mode |-> !nb_reg_en)
		else $error("northbridge on in parallel mode");
	a_mode_held: assert property (core_reg_en && $past(core_reg_en)
		|-> $stable(parallel_vid_mode))
		else $error("mode changed while running");
	a_count_held: assert property (core_reg_en && $past(core_reg_en)
		|-> $stable(active_chan_count))
		else $error("channel count changed while running");
	// pulses 1 and 4 stay quiet while off, phase 4 never fires unless four channels are active
	a_off_quiet: assert property ((!core_reg_en) [*3]
		|-> !phase_pulse_1 && !phase_pulse_4)
		else $error("phase pulse while disabled");
	a_unused_phase: assert property (active_chan_count != 3'h4
		|-> !phase_pulse_4)
		else $error("inactive phase fired");
	a_count_range: assert property (active_chan_count inside {[3'h1:3'h4]})
		else $error("channel count out of range");
endmodule

// file: verification/mps_board.sv
// board model: strap pins, select pin and enable sequencing
`timescale 1ns/1ps
module mps_board (
	// clock
	input wire logic core_clk,
	// bench commands
	input wire logic want_en,
	input wire logic want_sel,
	input wire logic [2:0] want_cnt,
	// board pins, strap is {chan4, chan3, chan2}
	output logic core_enable,
	output logic vid_mode_select,
	output logic [2:0] strap
);
	int hold = 0;
	initial begin
		core_enable = 1'b0;
		vid_mode_select = 1'b0;
		strap = 3'h0;
	end
	// enable waits 12 cycles so select is settled well before it rises
	always @(posedge core_clk) begin
		vid_mode_select <= want_sel;
		strap <= want_cnt == 3'h1 ? 3'h7 : want_cnt == 3'h2 ? 3'h6 :
			want_cnt == 3'h3 ? 3'h4 : 3'h0;
		if (!want_en) begin
			core_enable <= 1'b0;
			hold <= 0;
		end else if (hold < 12) begin
			hold <= hold + 1;
		end else begin
			core_enable <= 1'b1;
		end
	end
endmodule

// file: verification/tb_mps_sequencer.sv
// self-checking bench for the multiphase pwm sequencer
`timescale 1ns/1ps
module tb_mps_sequencer;
	logic core_clk = 1'b0, rst_n = 1'b0, align = 1'b0;
	logic want_en = 1'b0, want_sel = 1'b0;
	logic [2:0] want_cnt = 3'h4, strap, cnt;
	logic core_enable, vid_mode_select, pready, pslverr, nb, par, ser, cre;
	logic [3:0][7:0] cur = '0;
	logic [7:0] paddr = 8'h00, avg;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] ph, ph_d = 4'h0;
	logic [33:0] expq[$];
	int fails = 0, n_checks = 0, cyc = 0, seed = 29203;
	int rise[4] = '{-1, -1, -1, -1}, fall[4] = '{-1, -1, -1, -1};
	logic rec_clr = 1'b0;

	mps_sequencer u_mps_sequencer (.core_clk(core_clk), .rst_n(rst_n),
		.core_enable(core_enable), .vid_mode_select(vid_mode_select),
		.chan2_sense_strap(strap[0]), .chan3_sense_strap(strap[1]),
		.chan4_sense_strap(strap[2]), .phase_align_trigger(align),
		.chan_current(cur), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_pulse_1(ph[0]), .phase_pulse_2(ph[1]),
		.phase_pulse_3(ph[2]), .phase_pulse_4(ph[3]), .core_reg_en(cre),
		.nb_reg_en(nb), .parallel_vid_mode(par), .serial_vid_mode(ser),
		.active_chan_count(cnt), .cycle_avg_current(avg));
	mps_board u_mps_board (.core_clk(core_clk), .want_en(want_en),
		.want_sel(want_sel), .want_cnt(want_cnt), .core_enable(core_enable),
		.vid_mode_select(vid_mode_select), .strap(strap));

	always #50 core_clk = ~core_clk;

	task automatic print_verdict();
		if (fails == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] want);
		n_checks++;
		if (got !== want) begin
			fails++;
			$display("ERROR %0t got %h want %h", $time, got, want);
		end
	endtask

	// note carries {check data, error, data}; held until pready is sampled
	// one idle edge first, so a release is never undone in the same step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [33:0] note);
		@(posedge core_clk);
		expq.push_back(note);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// cycle count, hang guard and first edges of each pulse after arming
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		ph_d <= ph;
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
		if (rec_clr) begin
			rise <= '{-1, -1, -1, -1};
			fall <= '{-1, -1, -1, -1};
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (ph[k] && !ph_d[k] && rise[k] < 0) rise[k] <= cyc;
				if (!ph[k] && ph_d[k] && rise[k] >= 0 && fall[k] < 0)
					fall[k] <= cyc;
			end
		end
	end

	// every answer is matched against the oldest note
	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			if (expq[0][33]) chk({pslverr, prdata}, expq[0][32:0]);
			else chk({pslverr, 32'h0}, expq[0][32:0]);
			void'(expq.pop_front());
		end
	end

	task automatic run(input int n);
		int a, c;
		logic [3:0][7:0] v;
		a = 0;
		for (int k = 0; k < 4; k++) v[k] = 8'($random(seed)) & 8'h1F;
		for (int k = 0; k < n; k++) a += v[k];
		a = a / n;
		cur <= v;
		want_cnt <= 3'(n);
		want_sel <= n[0];
		repeat (4) @(posedge core_clk);
		want_en <= 1'b1;
		repeat (30) @(posedge core_clk);
		align <= 1'b1;
		want_sel <= ~n[0];
		repeat (8) @(posedge core_clk);
		apb(0, 8'h0C, 0, {2'h2, 25'h0, 2'h3, n[0], 1'b0, 3'(n)});
		align <= 1'b0;
		repeat (180) @(posedge core_clk);
		rec_clr <= 1'b1;
		@(posedge core_clk);
		rec_clr <= 1'b0;
		repeat (70) @(posedge core_clk);
		apb(0, 8'h10, 0, {2'h2, 32'(a)});
		chk(33'({cre, nb, par, ser, cnt, avg}),
			33'({1'b1, ~n[0], n[0], ~n[0], 3'(n), 8'(a)}));
		for (int k = 1; k < n; k++)
			chk(33'((rise[k] - rise[0] + 60) % 60), 33'(k * (60 / n)));
		for (int k = 0; k < n; k++) begin
			c = v[k];
			chk(33'(fall[k] - rise[k]), 33'(10 + ((a - c) >>> 2)));
		end
		want_en <= 1'b0;
		repeat (10) @(posedge core_clk);
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		apb(0, 8'h00, 0, {2'h2, 32'h1});
		apb(0, 8'h04, 0, {2'h2, 32'h64});
		apb(0, 8'h08, 0, {2'h2, 32'h14});
		apb(0, 8'h0C, 0, {2'h2, 32'h4});
		apb(0, 8'h10, 0, {2'h2, 32'h0});
		apb(0, 8'h14, 0, {2'h3, 32'h0});
		apb(1, 8'h04, 32'h1, 34'h0);
		apb(0, 8'h04, 0, {2'h2, 32'h4});
		apb(1, 8'h04, 32'h3C, 34'h0);
		apb(1, 8'h08, 32'h0A, 34'h0);
		for (int n = 1; n <= 4; n++) run(n);
		print_verdict();
	end
endmodule

bind mps_sequencer mps_seq_sva u_mps_seq_sva (.core_clk(core_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .phase_pulse_1(phase_pulse_1),
	.phase_pulse_4(phase_pulse_4), .core_reg_en(core_reg_en),
	.nb_reg_en(nb_reg_en), .parallel_vid_mode(parallel_vid_mode),
	.serial_vid_mode(serial_vid_mode),
	.active_chan_count(active_chan_count));
